//--- hdl/prsm_pkg.sv
// Package: constants and types for the page row-strobe manager
package prsm_pkg;
	localparam int NUM_BANKS = 4;
	localparam int ADDR_W = 23;
	localparam int ROW_W = 12;
	// Page column span: 1 KByte at 256K parts, 2 KByte at 1M parts
	localparam int PAGE_BITS_256K = 10;
	localparam int PAGE_BITS_1M = 11;
	// Bank select positions within the address
	localparam int BANK_LSB_256K = 10;
	localparam int BANK_LSB_1M = 11;
	// Timing
	localparam int CLOCK_MHZ = 125;
	localparam int TIMEOUT_US = 10;
	localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLOCK_MHZ;
	localparam int PRECHARGE_NS = 80;
	localparam int PRECHARGE_CYCLES = (PRECHARGE_NS * CLOCK_MHZ + 999) / 1000;
	localparam int NEW_ROW_WAITS = 1;
	localparam logic [1:0] ZERO_WAIT = 2'h0;

	typedef enum logic [1:0] {
		SLOW_TWO_WAIT_MODE = 2'b00,
		SLOW_ONE_WAIT_MODE = 2'b01,
		FAST_SINGLE_PAGE_MODE = 2'b10,
		FAST_MULTI_PAGE_MODE = 2'b11
	} prsm_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_DONE = 2'b10
	} prsm_state_t;
endpackage

//--- hdl/prsm_row_strobe.sv
// Row-strobe manager: page hit detection and per-bank strobe control
`timescale 1ns/1ps
`default_nettype none
module prsm_row_strobe
	import prsm_pkg::*;
#(
	parameter int TIMEOUT = TIMEOUT_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Configuration straps and speed select
	input wire logic fastMemoryStrap,
	input wire logic multiPageStrap,
	input wire logic dram1M,
	input wire logic [1:0] banksInstalled,
	input wire logic slowSelect,
	input wire logic holdAck,
	// Processor local bus
	input wire logic cycleStart,
	input wire logic localMem,
	input wire logic [ADDR_W:1] addr,
	input wire logic busIdle,
	input wire logic refreshStart,
	output logic ready,
	output logic pageHit,
	output logic bankHit,
	// DRAM side
	output logic [NUM_BANKS-1:0] rowStrobeN,
	output logic [1:0] accessBank,
	output logic [ROW_W-1:0] rowAddr,
	output logic newRow
);
	localparam int TW = $clog2(TIMEOUT + 1);
	localparam int WW = 4;
	localparam int TAGW = ADDR_W - PAGE_BITS_256K + 1;

	// ==================================================
	// Reset synchroniser
	logic rstSync1_reg, rstSync2_reg;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rstSync1_reg <= 1'b0;
			rstSync2_reg <= 1'b0;
		end else begin
			rstSync1_reg <= 1'b1;
			rstSync2_reg <= rstSync1_reg;
		end
	end
	wire logic rst = !rstSync2_reg;

	// ==================================================
	// Mode and speed select
	wire prsm_mode_t mode = prsm_mode_t'({fastMemoryStrap, multiPageStrap});
	wire logic singlePage = (mode == FAST_SINGLE_PAGE_MODE);
	logic holdAckDly_reg, nonTurbo_reg;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			holdAckDly_reg <= 1'b0;
			nonTurbo_reg <= 1'b0;
		end else begin
			holdAckDly_reg <= holdAck;
			if (holdAckDly_reg && !holdAck)
				nonTurbo_reg <= slowSelect;
		end
	end

	// ==================================================
	// Bank and row decode
	function automatic logic [1:0] bankOf(input logic [ADDR_W:1] a,
		input logic big, input logic [1:0] nb);
		logic [1:0] b;
		b = big ? a[BANK_LSB_1M +: 2] : a[BANK_LSB_256K +: 2];
		case (nb)
			2'd0: bankOf = 2'd0;
			2'd1: bankOf = {1'b0, b[0]};
			default: bankOf = b;
		endcase
	endfunction
	wire logic [1:0] bankSel = bankOf(addr, dram1M, banksInstalled);
	// Row bits sit above the page span
	wire logic [ROW_W-1:0] rowSel = dram1M ?
		ROW_W'(addr[ADDR_W:PAGE_BITS_1M + 2]) :
		ROW_W'(addr[ADDR_W:PAGE_BITS_256K + 2]);
	// Page tag keeps every bit above the page span, bank bits too, so
	// setups with fewer banks still split pages at the span
	wire logic [TAGW-1:0] pageTag = dram1M ?
		TAGW'(addr[ADDR_W:PAGE_BITS_1M]) : addr[ADDR_W:PAGE_BITS_256K];

	// ==================================================
	// Open page table and hit classification
	logic [TAGW-1:0] openRow_reg [NUM_BANKS];
	logic [NUM_BANKS-1:0] openValid_reg;
	logic [1:0] lastBank_reg;
	wire logic rowMatch = openValid_reg[bankSel] &&
		(openRow_reg[bankSel] == pageTag);
	wire logic isBankHit = (bankSel == lastBank_reg);
	// Single page: another bank's page never counts as open
	wire logic isPageHit = rowMatch && !nonTurbo_reg &&
		!(singlePage && !isBankHit);

	// Waits: page hit zero, new row at least one plus precharge
	wire logic [WW-1:0] missWaits = WW'(NEW_ROW_WAITS) +
		((openValid_reg[bankSel] && !rowMatch) ? WW'(PRECHARGE_CYCLES) :
		WW'(0));

	// ==================================================
	// Cycle sequencer
	prsm_state_t state_reg, state_next;
	logic [WW-1:0] waitCnt_reg;
	wire logic accessGo = cycleStart && localMem && (state_reg == ST_IDLE);
	wire logic cycleEnd = (state_reg == ST_DONE);
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: if (accessGo)
				state_next = isPageHit ? ST_DONE : ST_WAIT;
			ST_WAIT: if (waitCnt_reg == WW'(1)) state_next = ST_DONE;
			ST_DONE: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end
	assign ready = cycleEnd;

	// ==================================================
	// Timeout timers
	logic [TW-1:0] timer_reg [NUM_BANKS];
	logic [NUM_BANKS-1:0] timedOut_reg;
	logic [NUM_BANKS-1:0] strobeOn_reg;

	wire logic releaseAll = (cycleStart && !localMem) || busIdle || holdAck ||
		(cycleEnd && nonTurbo_reg);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			waitCnt_reg <= WW'(ZERO_WAIT);
			lastBank_reg <= 2'd0;
			pageHit <= 1'b0;
			bankHit <= 1'b0;
			accessBank <= 2'd0;
			rowAddr <= '0;
			newRow <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (accessGo) begin
				waitCnt_reg <= missWaits;
				pageHit <= isPageHit;
				bankHit <= isBankHit;
				accessBank <= bankSel;
				rowAddr <= rowSel;
				newRow <= !isPageHit;
				lastBank_reg <= bankSel;
			end else if (state_reg == ST_WAIT) begin
				waitCnt_reg <= waitCnt_reg - WW'(1);
			end
		end
	end

	// Per bank strobe, open page and timer
	for (genvar b = 0; b < NUM_BANKS; b++) begin : gBank
		wire logic hitMe = accessGo && (bankSel == 2'(b));
		wire logic missMe = hitMe && !isPageHit;
		wire logic switchOff = accessGo && singlePage && !nonTurbo_reg &&
			(lastBank_reg == 2'(b)) && (bankSel != 2'(b));
		// A timed-out bank being taken holds its strobe to cycle end
		wire logic timeRelease = timedOut_reg[b] &&
			(cycleEnd || (state_reg == ST_IDLE && !hitMe));
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				strobeOn_reg[b] <= 1'b0;
				openValid_reg[b] <= 1'b0;
				openRow_reg[b] <= '0;
				timer_reg[b] <= '0;
				timedOut_reg[b] <= 1'b0;
			end else begin
				if (refreshStart) begin
					strobeOn_reg[b] <= 1'b1;
					openValid_reg[b] <= 1'b0;
				end else if (releaseAll || switchOff || timeRelease) begin
					strobeOn_reg[b] <= 1'b0;
					openValid_reg[b] <= 1'b0;
				end else if (hitMe) begin
					strobeOn_reg[b] <= 1'b1;
					openValid_reg[b] <= 1'b1;
					openRow_reg[b] <= pageTag;
				end
				if (!strobeOn_reg[b] || missMe) begin
					timer_reg[b] <= '0;
					timedOut_reg[b] <= 1'b0;
				end else if (timer_reg[b] >= TW'(TIMEOUT - 1)) begin
					timedOut_reg[b] <= 1'b1;
				end else begin
					timer_reg[b] <= timer_reg[b] + TW'(1);
				end
			end
		end
		// Page miss drops this bank's strobe during the precharge wait
		assign rowStrobeN[b] = !(strobeOn_reg[b] &&
			!(state_reg == ST_WAIT && accessBank == 2'(b) && newRow &&
			waitCnt_reg > WW'(NEW_ROW_WAITS)));
	end
endmodule // prsm_row_strobe
`default_nettype wire

//--- sim/prsm_dram_model.sv
// DRAM bank model: flags a row held open too long
`timescale 1ns/1ps
`default_nettype none
module prsm_dram_model
	import prsm_pkg::*;
#(parameter int LIMIT = 40) (
	input wire logic clock,
	input wire logic [NUM_BANKS-1:0] rowStrobeN,
	output logic overRun = 1'b0
);
	int onTime [NUM_BANKS] = '{default: 0};
	always @(posedge clock)
		for (int b = 0; b < NUM_BANKS; b++) begin
			onTime[b] = rowStrobeN[b] ? 0 : onTime[b] + 1;
			if (onTime[b] > LIMIT) overRun <= 1'b1;
		end
endmodule // prsm_dram_model
`default_nettype wire

//--- sim/prsm_row_strobe_chk.sv
// Checker: row-strobe properties at the manager's ports
`timescale 1ns/1ps
`default_nettype none
module prsm_row_strobe_chk
	import prsm_pkg::*;
#(parameter int TIMEOUT = 20) (
	input wire logic clock, rstn, fastMemoryStrap, multiPageStrap,
	input wire logic slowSelect, holdAck, cycleStart, localMem, busIdle,
	input wire logic refreshStart, ready, pageHit, newRow,
	input wire logic [NUM_BANKS-1:0] rowStrobeN,
	input wire logic [1:0] accessBank
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		logic [10:0] onTime_reg;
		always_ff @(posedge clock or negedge rstn)
			if (!rstn) onTime_reg <= '0;
			else onTime_reg <= rowStrobeN[b] ? '0 : onTime_reg + 1'b1;
		a_open_bounded: assert property (
			onTime_reg <= 11'(TIMEOUT + 16)) else $error("row open too long");
	end
	a_row_waits: assert property (ready && newRow |->
		!$past(cycleStart && localMem)) else $error("new row took no wait");
	a_hit_no_wait: assert property (ready && pageHit |->
		$past(cycleStart) && !rowStrobeN[accessBank]) else $error("slow hit");
	a_refresh_all: assert property (refreshStart && !holdAck && !busIdle
		|=> rowStrobeN == '0) else $error("refresh missed a bank");
	a_hold_idle_off: assert property ((holdAck || busIdle) &&
		!refreshStart |=> &rowStrobeN) else $error("row kept in hold");
	a_nonlocal_off: assert property (cycleStart && !localMem
		|=> &rowStrobeN) else $error("row kept on other cycle");
	// Speed select as taken at the hold-acknowledge fall
	logic holdAckDly_reg, slowLatched_reg;
	always_ff @(posedge clock or negedge rstn)
		if (!rstn) begin
			holdAckDly_reg <= 1'b0;
			slowLatched_reg <= 1'b0;
		end else begin
			holdAckDly_reg <= holdAck;
			if (holdAckDly_reg && !holdAck) slowLatched_reg <= slowSelect;
		end
	a_slow_closes: assert property (ready && slowLatched_reg |->
		!pageHit ##1 &rowStrobeN) else $error("page kept in non-turbo");
	a_single_page: assert property (fastMemoryStrap && !multiPageStrap
		&& ready |=> $onehot0(~rowStrobeN)) else $error("two pages open");
	c_hit: cover property (ready && pageHit);
	c_miss: cover property (ready && newRow);
	c_refresh: cover property (refreshStart);
endmodule // prsm_row_strobe_chk
bind prsm_row_strobe prsm_row_strobe_chk #(.TIMEOUT(TIMEOUT))
	i_prsm_row_strobe_chk (.clock, .rstn, .fastMemoryStrap, .multiPageStrap,
	.slowSelect, .holdAck, .cycleStart, .localMem, .busIdle, .refreshStart,
	.ready, .pageHit, .newRow, .rowStrobeN, .accessBank);
`default_nettype wire

//--- sim/prsm_row_strobe_bench.sv
// Bench: random and corner-case accesses for the row-strobe manager
`timescale 1ns/1ps
`default_nettype none
module prsm_row_strobe_bench
	import prsm_pkg::*;
;
	localparam int TMO = 64;
	logic clock = 1'b0, rstn = 1'b0, fastMemoryStrap = 1'b1, busIdle = 1'b0;
	logic multiPageStrap = 1'b1, dram1M = 1'b0, slowSelect = 1'b0, hit;
	logic holdAck = 1'b0, cycleStart = 1'b0, localMem = 1'b0;
	logic refreshStart = 1'b0, ready, pageHit, newRow, overRun, bankHit;
	logic [1:0] banksInstalled = 2'h3, accessBank, lastBk = 2'h0;
	logic [ROW_W-1:0] rowAddr;
	logic [ADDR_W:1] addr = '0;
	logic [NUM_BANKS-1:0] rowStrobeN;
	logic [31:0] seed = 32'h5f6d;
	int error_cnt = 0, n_checks = 0, cyc = 0, waits;
	prsm_row_strobe #(.TIMEOUT(TMO)) i_prsm_row_strobe (.clock, .rstn,
		.fastMemoryStrap, .multiPageStrap, .dram1M, .banksInstalled,
		.slowSelect, .holdAck, .cycleStart, .localMem, .addr, .busIdle,
		.refreshStart, .ready, .pageHit, .bankHit, .accessBank,
		.rowAddr, .rowStrobeN, .newRow);
	prsm_dram_model #(.LIMIT(TMO + 16)) i_prsm_dram_model (.clock,
		.rowStrobeN, .overRun);
	initial forever #4 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			complete_run();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	function automatic logic [1:0] bankExp(input logic [ADDR_W:0] ba);
		logic [1:0] b;
		b = dram1M ? ba[BANK_LSB_1M +: 2] : ba[BANK_LSB_256K +: 2];
		if (banksInstalled == 2'h0) b = 2'h0;
		if (banksInstalled == 2'h1) b[1] = 1'b0;
		return b;
	endfunction
	function automatic logic [ADDR_W:0] rowExp(input logic [ADDR_W:0] ba);
		return ba >> ((dram1M ? BANK_LSB_1M : BANK_LSB_256K) + 2);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			error_cnt++;
			$display("unexpected at %0t: got %0h want %0h", $time, seen, want);
		end
	endtask
	task automatic acc(input logic [ADDR_W:0] ba, input logic lm, eh);
		logic [1:0] bk;
		@(posedge clock);
		cycleStart <= 1'b1;
		localMem <= lm;
		addr <= ba[ADDR_W:1];
		@(posedge clock);
		cycleStart <= 1'b0;
		waits = 0;
		@(negedge clock);
		while (lm && ready !== 1'b1 && waits < 40) begin
			@(negedge clock);
			waits++;
		end
		hit = pageHit;
		if (lm) chk(hit, eh);
		if (lm) chk({waits < 40, waits == 0}, {1'b1, eh});
		bk = bankExp(ba);
		if (lm) chk(accessBank, bk);
		if (lm) chk(bankHit, bk == lastBk);
		if (lm) chk(rowAddr, rowExp(ba));
		if (lm) lastBk = bk;
	endtask
	task automatic quiet(input logic h, input logic slow);
		@(posedge clock);
		slowSelect <= slow;
		holdAck <= h;
		busIdle <= !h;
		repeat (2) @(posedge clock);
		holdAck <= 1'b0;
		busIdle <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	initial begin
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		repeat (4) @(posedge clock);
		acc(24'h0000, 1'b1, 1'b0);
		repeat (16) begin
			seed = xs(seed);
			acc({14'h0000, seed[9:0]}, 1'b1, 1'b1);
		end
		acc(24'h1000, 1'b1, 1'b0);
		for (int m = 3; m >= 0; m--) begin
			@(posedge clock);
			{fastMemoryStrap, multiPageStrap} <= 2'(m);
			quiet(1'b0, 1'b0);
			acc(24'h0000, 1'b1, 1'b0);
			acc(24'h0400, 1'b1, 1'b0);
			acc(24'h0000, 1'b1, m != 2);
		end
		@(posedge clock);
		{fastMemoryStrap, multiPageStrap, dram1M} <= 3'h7;
		quiet(1'b0, 1'b0);
		acc(24'h0000, 1'b1, 1'b0);
		acc(24'h0400, 1'b1, 1'b1);
		@(posedge clock);
		{dram1M, banksInstalled} <= 3'h0;
		quiet(1'b0, 1'b0);
		acc(24'h0000, 1'b1, 1'b0);
		acc(24'h0400, 1'b1, 1'b0);
		acc(24'h0400, 1'b0, 1'b0);
		acc(24'h0400, 1'b1, 1'b0);
		@(posedge clock);
		refreshStart <= 1'b1;
		@(posedge clock);
		refreshStart <= 1'b0;
		@(negedge clock);
		chk(rowStrobeN, 4'h0);
		repeat (TMO + 20) @(posedge clock);
		chk(rowStrobeN, 4'hf);
		quiet(1'b1, 1'b1);
		acc(24'h0000, 1'b1, 1'b0);
		acc(24'h0000, 1'b1, 1'b0);
		chk(overRun, 1'b0);
		complete_run();
	end
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
endmodule // prsm_row_strobe_bench
`default_nettype wire
